/* File: hdl/frs_rate_select.sv */
// Purpose: data rate / precompensation select register with density pin mapping
// Assumes: AHB-Lite single word transfers, one slave
// Notes: reads take one wait state, writes none
//
// The AHB-Lite slave port is this design's own decision.
`timescale 1ns/10ps
`default_nettype none
`include "frs_consts.svh"

// Summary of operation
// - type readback picks F2 pair by drive
// - rate select register is write only
// - active rate is last rate written
// - bus reset loads 02H, soft reset keeps
// - bits 1:0 hold rate code
// - bits 4:2 select write precompensation
// - precomp code maps to ns steps
// - code 000 gives rate dependent default
// - precomp starts at track 0, configurable
// - bit 6 enters manual low power
// - reset or data/status access exits low power
// - bit 7 resets controller, self clearing
// - every rate select write kept in shadow copy
// - type 00 rate codes and density
// - code 01 differs for 3-mode and tape
// - rate and density drive pins, density inverted for 3-mode kind
// - density pins follow drive kind
module frs_rate_select (
   input wire logic hclk, // bus clock, 40 MHz
   input wire logic hresetn, // bus reset, active low
   input wire logic hsel, // slave select
   input wire logic [31:0] haddr, // byte address
   input wire logic [1:0] htrans, // transfer type
   input wire logic hwrite, // write when high
   input wire logic [2:0] hsize, // transfer size
   input wire logic [31:0] hwdata, // write data
   input wire logic hready, // bus ready
   output logic hreadyout, // slave ready
   output logic hresp, // always okay
   output logic [31:0] hrdata, // read data
   input wire logic [1:0] drive_sel, // drive select from digital_output_reg
   input wire logic fdc_soft_reset, // controller software reset, high
   output frs_pkg::frs_pins_type drive_density, // drive density pins
   output logic density_level, // density signal
   output logic [11:0] data_rate_kbps, // active mfm rate
   output logic [17:0] precomp_delay_ps, // write precompensation delay
   output logic [7:0] precomp_start_track, // first precompensated track
   output logic low_power, // clock and separator stopped
   output logic ctrl_reset // controller reset pulse
);
   localparam int RST_CYC_I = (`FRS_RST_NS * 1000 + `FRS_CLK_PS - 1) / `FRS_CLK_PS;
   localparam logic [2:0] RST_CYC = 3'(RST_CYC_I);

   // ---------------------------------------------------------------
   // bus slave
   // ---------------------------------------------------------------
   logic wr_pend, next_wr_pend;
   logic rd_pend, next_rd_pend;
   logic [11:0] addr_q, next_addr_q;
   logic next_hreadyout;
   logic [31:0] next_hrdata, rd_val;
   logic accept, access_evt;
   frs_pkg::frs_dsr_type dsr, next_dsr;
   logic [1:0] rate, next_rate;
   logic [7:0] shadow, next_shadow;
   logic [15:0] cfga, next_cfga;
   frs_pkg::frs_drv_cfg_type [3:0] cfgb, next_cfgb;
   logic [2:0] rst_cnt, next_rst_cnt;
   logic next_low_power, next_ctrl_reset;
   frs_pkg::frs_drv_cfg_type sel_cfg;
   frs_pkg::frs_pins_type next_pins;
   logic next_density;
   logic [11:0] next_kbps;
   logic [17:0] next_delay;
   logic wr_rate, wr_ccr;

   assign accept = hsel && htrans[1] && hready && (hsize == `FRS_HSIZE_WORD);
   // data register or status read wakes the controller
   assign access_evt = accept && ((haddr[13:2] == `FRS_IDX_DATA) ||
      (!hwrite && haddr[13:2] == `FRS_IDX_RATE));

   // read mux; the rate select address reads zero here
   always_comb begin
      unique case (addr_q)
         `FRS_IDX_TYPE: rd_val = {26'h0, cfga[{drive_sel, 1'b0} +: 2], 4'h0};
         `FRS_IDX_SHADOW: rd_val = {24'h0, shadow};
         `FRS_IDX_CFGA: rd_val = {16'h0, cfga};
         `FRS_IDX_CFGB: rd_val = {16'h0, cfgb};
         `FRS_IDX_STAT: rd_val = {precomp_delay_ps, 7'h0, ctrl_reset, low_power,
            drive_density, density_level, rate};
         default: rd_val = 32'h0000_0000;
      endcase
   end

   // address phase capture; a read waits one cycle so a write just before it has landed
   always_comb begin
      next_wr_pend = accept && hwrite;
      next_rd_pend = accept && !hwrite;
      next_addr_q = addr_q;
      if (accept) begin
         next_addr_q = (haddr[31:14] == 18'h0_0000) ? haddr[13:2] : `FRS_IDX_NONE;
      end
      next_hreadyout = !(accept && !hwrite);
      next_hrdata = rd_pend ? rd_val : hrdata;
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend <= 1'b0;
         rd_pend <= 1'b0;
         addr_q <= `FRS_IDX_NONE;
         hreadyout <= 1'b1;
         hrdata <= 32'h0000_0000;
         hresp <= 1'b0;
      end else begin
         wr_pend <= next_wr_pend;
         rd_pend <= next_rd_pend;
         addr_q <= next_addr_q;
         hreadyout <= next_hreadyout;
         hrdata <= next_hrdata;
         hresp <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // registers and control
   // ---------------------------------------------------------------
   assign wr_rate = wr_pend && (addr_q == `FRS_IDX_RATE);
   assign wr_ccr = wr_pend && (addr_q == `FRS_IDX_CCR);

   // soft reset touches none of these; only the bus reset restores them
   always_comb begin
      next_dsr = dsr;
      next_rate = rate;
      next_shadow = shadow;
      next_cfga = cfga;
      next_cfgb = cfgb;
      if (wr_rate) begin
         next_dsr = hwdata[7:0];
         next_dsr.swrst = 1'b0;
         next_dsr.rsv = 1'b0;
         next_shadow = hwdata[7:0];
         next_rate = hwdata[1:0];
      end
      if (wr_ccr) begin
         next_rate = hwdata[1:0];
      end
      if (wr_pend && addr_q == `FRS_IDX_CFGA) begin
         next_cfga = hwdata[15:0];
      end
      if (wr_pend && addr_q == `FRS_IDX_CFGB) begin
         next_cfgb = hwdata[15:0];
      end
   end

   // reset pulse stretched to the minimum controller reset width
   always_comb begin
      next_rst_cnt = rst_cnt;
      if (wr_rate && hwdata[7]) begin
         next_rst_cnt = RST_CYC;
      end else if (rst_cnt != 3'h0) begin
         next_rst_cnt = rst_cnt - 3'h1;
      end
      next_ctrl_reset = (next_rst_cnt != 3'h0);
      // a new entry request wins over a wake event in the same cycle
      next_low_power = low_power;
      if (fdc_soft_reset || ctrl_reset || access_evt) begin
         next_low_power = 1'b0;
      end
      if (wr_rate && hwdata[6]) begin
         next_low_power = 1'b1;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dsr <= `FRS_DSR_RESET;
         rate <= `FRS_RATE_RESET;
         shadow <= `FRS_DSR_RESET;
         cfga <= 16'h0000;
         cfgb <= 16'h0000;
         rst_cnt <= 3'h0;
         ctrl_reset <= 1'b0;
         low_power <= 1'b0;
      end else begin
         dsr <= next_dsr;
         rate <= next_rate;
         shadow <= next_shadow;
         cfga <= next_cfga;
         cfgb <= next_cfgb;
         rst_cnt <= next_rst_cnt;
         ctrl_reset <= next_ctrl_reset;
         low_power <= next_low_power;
      end
   end

   // ---------------------------------------------------------------
   // rate, density and precompensation decode
   // ---------------------------------------------------------------
   assign sel_cfg = cfgb[drive_sel];

   always_comb begin
      unique case (rate)
         `FRS_RATE_1M: next_kbps = `FRS_KBPS_1M;
         `FRS_RATE_500: next_kbps = `FRS_KBPS_500;
         `FRS_RATE_250: next_kbps = `FRS_KBPS_250;
         `FRS_RATE_300: begin
            if (sel_cfg.rtype == `FRS_RTYPE_3MODE) begin
               next_kbps = `FRS_KBPS_500;
            end else if (sel_cfg.rtype == `FRS_RTYPE_TAPE) begin
               next_kbps = `FRS_KBPS_2M;
            end else begin
               next_kbps = `FRS_KBPS_300;
            end
         end
      endcase
      next_density = (rate == `FRS_RATE_1M) || (rate == `FRS_RATE_500);
      // pins carry raw code bits and density; the 3-mode kind inverts density
      unique case (sel_cfg.kind)
         `FRS_KIND_STD: next_pins = {rate[0], next_density};
         `FRS_KIND_TAPE: next_pins = {rate[0], rate[1]};
         `FRS_KIND_3MODE: next_pins = {rate[0], !next_density};
         default: next_pins = {rate[1], rate[0]};
      endcase
      // steps use the rate in force, so 2 Mbps halves the step
      if (dsr.precomp == `FRS_PC_ZERO) begin
         next_delay = 18'h0_0000;
      end else if (dsr.precomp == `FRS_PC_DEF) begin
         if (next_kbps == `FRS_KBPS_2M) begin
            next_delay = `FRS_DEF_2M_PS;
         end else if (next_kbps == `FRS_KBPS_1M) begin
            next_delay = `FRS_DEF_1M_PS;
         end else begin
            next_delay = `FRS_DEF_LO_PS;
         end
      end else if (next_kbps == `FRS_KBPS_2M) begin
         next_delay = 18'({15'h0000, dsr.precomp} * `FRS_STEP_2M_PS);
      end else begin
         next_delay = 18'({15'h0000, dsr.precomp} * `FRS_STEP_LO_PS);
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         data_rate_kbps <= `FRS_KBPS_250;
         density_level <= 1'b0;
         drive_density <= 2'h0;
         precomp_delay_ps <= `FRS_DEF_LO_PS;
         precomp_start_track <= 8'h00;
      end else begin
         data_rate_kbps <= next_kbps;
         density_level <= next_density;
         drive_density <= next_pins;
         precomp_delay_ps <= next_delay;
         precomp_start_track <= cfga[15:8];
      end
   end

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   rate_read_zero_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (rd_pend && addr_q == `FRS_IDX_RATE) |=> (hreadyout && hrdata == 32'h0000_0000))
      else $error("rate select read not zero");
   dsr_write_rate_a: assert property (@(posedge hclk) disable iff (!hresetn)
      wr_rate |=> (rate == $past(hwdata[1:0])) ##1 (density_level == (rate[1] == rate[0])))
      else $error("rate write not applied");
   ccr_write_rate_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (wr_ccr && !wr_rate) |=> rate == $past(hwdata[1:0]))
      else $error("ccr rate write not applied");
   shadow_copy_a: assert property (@(posedge hclk) disable iff (!hresetn)
      wr_rate |=> shadow == $past(hwdata[7:0]))
      else $error("shadow not updated");
   tape_rate_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (rate == `FRS_RATE_300 && sel_cfg.rtype == `FRS_RTYPE_TAPE) |=>
      data_rate_kbps == `FRS_KBPS_2M)
      else $error("tape rate wrong");
   pins_swap_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (sel_cfg.kind == 2'h3) |=> drive_density == $past(rate))
      else $error("density pins wrong");
   precomp_zero_a: assert property (@(posedge hclk) disable iff (!hresetn)
      dsr.precomp == `FRS_PC_ZERO |=> precomp_delay_ps == 18'h0_0000)
      else $error("zero precomp wrong");
   precomp_default_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (dsr.precomp == `FRS_PC_DEF && rate == `FRS_RATE_250) |=>
      precomp_delay_ps == `FRS_DEF_LO_PS)
      else $error("default precomp wrong");
   reset_pulse_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (wr_rate && hwdata[7] && rst_cnt == 3'h0) |=> ctrl_reset [*4] ##1 !ctrl_reset)
      else $error("reset pulse width wrong");
   lp_exit_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (fdc_soft_reset && !(wr_rate && hwdata[6])) |=> !low_power)
      else $error("low power not left");
   lp_enter_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (wr_rate && hwdata[6]) |=> low_power)
      else $error("low power not entered");
   // a controller soft reset must leave the rate select contents alone
   soft_reset_keep_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (fdc_soft_reset && !wr_rate && !wr_ccr) |=> (rate == $past(rate) && dsr == $past(dsr)))
      else $error("soft reset changed rate select");
endmodule
`default_nettype wire

/* File: hdl/frs_consts.svh */
// Purpose: named constants of the rate and precompensation select block
// Assumes: register index = byte address / 4
// Notes: definitions only
`ifndef FRS_CONSTS_SVH
`define FRS_CONSTS_SVH
// register indices
`define FRS_IDX_TYPE 12'h3F3
`define FRS_IDX_RATE 12'h3F4
`define FRS_IDX_DATA 12'h3F5
`define FRS_IDX_CCR 12'h3F7
`define FRS_IDX_SHADOW 12'h01F
`define FRS_IDX_CFGA 12'h040
`define FRS_IDX_CFGB 12'h041
`define FRS_IDX_STAT 12'h042
`define FRS_IDX_NONE 12'hFFF
// bus
`define FRS_HSIZE_WORD 3'h2
// reset values
`define FRS_DSR_RESET 8'h02
`define FRS_RATE_RESET 2'h2
// rate codes
`define FRS_RATE_1M 2'h3
`define FRS_RATE_500 2'h0
`define FRS_RATE_300 2'h1
`define FRS_RATE_250 2'h2
// drive rate types and drive kinds
`define FRS_RTYPE_3MODE 2'h1
`define FRS_RTYPE_TAPE 2'h2
`define FRS_KIND_STD 2'h0
`define FRS_KIND_3MODE 2'h1
`define FRS_KIND_TAPE 2'h2
// mfm rates in kbps
`define FRS_KBPS_2M 12'h7D0
`define FRS_KBPS_1M 12'h3E8
`define FRS_KBPS_500 12'h1F4
`define FRS_KBPS_300 12'h12C
`define FRS_KBPS_250 12'h0FA
// precompensation codes, and steps and defaults in ps
`define FRS_PC_ZERO 3'h7
`define FRS_PC_DEF 3'h0
`define FRS_STEP_LO_PS 18'h0_A2C3
`define FRS_STEP_2M_PS 18'h0_5161
`define FRS_DEF_2M_PS 18'h0_5161
`define FRS_DEF_1M_PS 18'h0_A2C3
`define FRS_DEF_LO_PS 18'h1_E848
// timing
`define FRS_CLK_PS 25000
`define FRS_RST_NS 100
`endif

/* File: hdl/frs_pkg.sv */
// Purpose: types of the rate and precompensation select block
// Assumes: nothing
// Notes: imported by no one; use frs_pkg::name
package frs_pkg;
   typedef struct packed {
      logic swrst;
      logic lowpow;
      logic rsv;
      logic [2:0] precomp;
      logic [1:0] rate;
   } frs_dsr_type;
   typedef struct packed {
      logic [1:0] kind;
      logic [1:0] rtype;
   } frs_drv_cfg_type;
   typedef struct packed {
      logic pin1;
      logic pin0;
   } frs_pins_type;
endpackage

/* File: bench/frs_drive_model.sv */
// Purpose: drive end of the cable, latching the density select pins
// Assumes: drive samples the pins on the controller clock
// Notes: passive; it never drives anything back
`timescale 1ns/10ps
`default_nettype none

module frs_drive_model (
   input wire logic hclk, // controller clock
   input wire frs_pkg::frs_pins_type drive_density, // density pins from controller
   output logic [1:0] seen_pins // pins as latched by the drive
);
   // a real drive only reacts to settled levels, so latch them
   always_ff @(posedge hclk) begin
      seen_pins <= {drive_density.pin1, drive_density.pin0};
   end
endmodule

`default_nettype wire

/* File: bench/testbench.sv */
// Purpose: self-checking bench of the rate and precompensation select block
// Assumes: one ahb-lite slave, hready fed back from hreadyout
// Notes: expectations are worked out here, never read from the design
`timescale 1ns/10ps
`default_nettype none
`include "frs_consts.svh"

module testbench;
   logic hclk, hresetn, hsel, hwrite, fdc_soft_reset, hreadyout, hresp;
   logic [31:0] haddr, hwdata, hrdata, v;
   logic [1:0] htrans, drive_sel, seen;
   logic [2:0] hsize;
   frs_pkg::frs_pins_type drive_density;
   logic density_level, low_power, ctrl_reset;
   logic [11:0] data_rate_kbps;
   logic [17:0] precomp_delay_ps;
   logic [7:0] precomp_start_track;
   int fail_count, compares, n;
   wire hready;
   assign hready = hreadyout;

   frs_rate_select uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .drive_sel(drive_sel),
      .fdc_soft_reset(fdc_soft_reset), .drive_density(drive_density),
      .density_level(density_level), .data_rate_kbps(data_rate_kbps),
      .precomp_delay_ps(precomp_delay_ps), .precomp_start_track(precomp_start_track),
      .low_power(low_power), .ctrl_reset(ctrl_reset));
   frs_drive_model drive (.hclk(hclk), .drive_density(drive_density), .seen_pins(seen));

   // ----------------------------------------
   // bus access and comparison
   // ----------------------------------------
   // master holds each phase until hready is seen high; bounded wait
   task automatic bus(input logic [11:0] idx, input logic wr, input logic [31:0] wd,
         output logic [31:0] rd);
      int k;
      k = 0;
      hsel <= 1'b1;
      haddr <= {18'h0, idx, 2'b00};
      hwrite <= wr;
      htrans <= 2'b10;
      do begin
         @(posedge hclk);
         k++;
      end while (hready !== 1'b1 && k < 50);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= wd;
      do begin
         @(posedge hclk);
         k++;
      end while (hready !== 1'b1 && k < 50);
      rd = hrdata;
      if (k >= 50) begin
         fail_count++;
         $display("wrong value at %0t: bus stalled", $time);
      end
   endtask
   task automatic wr(input logic [11:0] idx, input logic [31:0] d);
      logic [31:0] x;
      bus(idx, 1'b1, d, x);
   endtask
   task automatic rd(input logic [11:0] idx, output logic [31:0] d);
      bus(idx, 1'b0, 32'h0000_0000, d);
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         fail_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // derived outputs lag the register by one edge, the drive by one more
   task automatic settle();
      repeat (3) @(posedge hclk);
   endtask

   // ----------------------------------------
   // reference decode
   // ----------------------------------------
   function automatic logic [11:0] ekbps(input logic [1:0] rt, input logic [1:0] rc);
      if (rc == 2'h3) return `FRS_KBPS_1M;
      if (rc == 2'h0) return `FRS_KBPS_500;
      if (rc == 2'h2) return `FRS_KBPS_250;
      return (rt == 2'h1) ? `FRS_KBPS_500 : (rt == 2'h2) ? `FRS_KBPS_2M : `FRS_KBPS_300;
   endfunction
   function automatic logic [1:0] epins(input logic [1:0] k, input logic [1:0] rc);
      logic d;
      d = (rc == 2'h3) || (rc == 2'h0);
      case (k)
         2'h0: return {rc[0], d};
         2'h2: return {rc[0], rc[1]};
         2'h1: return {rc[0], ~d};
         default: return {rc[1], rc[0]};
      endcase
   endfunction
   function automatic logic [17:0] edly(input logic [2:0] c, input logic [11:0] kb);
      logic fast;
      fast = (kb == `FRS_KBPS_2M);
      if (c == 3'h7) return 18'h0_0000;
      if (c != 3'h0) return c * (fast ? `FRS_STEP_2M_PS : `FRS_STEP_LO_PS);
      return fast ? `FRS_DEF_2M_PS : (kb == `FRS_KBPS_1M) ? `FRS_DEF_1M_PS : `FRS_DEF_LO_PS;
   endfunction

   task automatic conclude();
      $display("comparisons %0d, mismatches %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   // ----------------------------------------
   // clock, watchdog, tests
   // ----------------------------------------
   initial begin
      hclk = 1'b0;
      forever #12.5 hclk = ~hclk;
   end
   // whole sequence needs well under 3000 cycles
   initial begin
      repeat (20000) @(posedge hclk);
      fail_count++;
      conclude();
   end
   initial begin
      {hsel, hwrite, fdc_soft_reset, htrans, drive_sel} = '0;
      haddr = 32'h0000_0000;
      hwdata = 32'h0000_0000;
      hsize = `FRS_HSIZE_WORD;
      fail_count = 0;
      compares = 0;
      hresetn = 1'b0;
      repeat (12) @(posedge hclk);
      hresetn <= 1'b1;
      rd(`FRS_IDX_SHADOW, v);
      chk(v, 32'h0000_0002);
      chk(data_rate_kbps, `FRS_KBPS_250);
      chk(precomp_delay_ps, `FRS_DEF_LO_PS);
      rd(`FRS_IDX_RATE, v);
      chk(v, 32'h0000_0000);
      chk(hresp, 1'b0);
      rd(`FRS_IDX_NONE, v);
      chk(v, 32'h0000_0000);
      // every rate code under each drive rate type; bit 5 always written 0
      for (int rt = 0; rt < 3; rt++) begin
         for (int rc = 0; rc < 4; rc++) begin
            wr(`FRS_IDX_CFGB, {30'h0, rt[1:0]});
            wr(`FRS_IDX_RATE, {27'h0, 3'h7, rc[1:0]});
            settle();
            chk(data_rate_kbps, ekbps(rt[1:0], rc[1:0]));
            chk(density_level, rc == 3 || rc == 0);
            chk(precomp_delay_ps, 18'h0_0000);
         end
      end
      // precompensation codes at 250k, 2M and 1M
      for (int j = 0; j < 3; j++) begin
         wr(`FRS_IDX_CFGB, (j == 1) ? 32'h0000_0002 : 32'h0000_0000);
         for (int c = 0; c < 7; c++) begin
            wr(`FRS_IDX_RATE, {27'h0, c[2:0], (j == 0) ? 2'h2 : (j == 1) ? 2'h1 : 2'h3});
            settle();
            chk(precomp_delay_ps, edly(c[2:0], (j == 0) ? `FRS_KBPS_250 :
               (j == 1) ? `FRS_KBPS_2M : `FRS_KBPS_1M));
         end
      end
      wr(`FRS_IDX_CCR, 32'h0000_0003);
      settle();
      chk(data_rate_kbps, `FRS_KBPS_1M);
      wr(`FRS_IDX_RATE, 32'h0000_001D);
      settle();
      chk(data_rate_kbps, `FRS_KBPS_300);
      // status word: delay 0, pin1 = rate bit0, density low, code 01
      rd(`FRS_IDX_STAT, v);
      chk(v, 32'h0000_0011);
      // pin mapping for every drive kind and rate code
      for (int k = 0; k < 4; k++) begin
         for (int rc = 0; rc < 4; rc++) begin
            wr(`FRS_IDX_CFGB, {28'h0, k[1:0], 2'h0});
            wr(`FRS_IDX_RATE, {27'h0, 3'h7, rc[1:0]});
            settle();
            chk({30'h0, seen}, {30'h0, epins(k[1:0], rc[1:0])});
         end
      end
      // per-drive config and type readback
      wr(`FRS_IDX_CFGA, 32'h0000_05E4);
      wr(`FRS_IDX_CFGB, 32'h0000_0210);
      wr(`FRS_IDX_RATE, 32'h0000_001D);
      for (int d = 0; d < 4; d++) begin
         drive_sel <= d[1:0];
         settle();
         rd(`FRS_IDX_TYPE, v);
         chk({30'h0, v[5:4]}, {30'h0, d[1:0]});
         chk(data_rate_kbps, ekbps((d == 3) ? 2'h0 : d[1:0], 2'h1));
      end
      chk(precomp_start_track, 8'h05);
      drive_sel <= 2'h0;
      // low power entry and the three ways out
      wr(`FRS_IDX_RATE, 32'h0000_0042);
      settle();
      chk(low_power, 1'b1);
      rd(`FRS_IDX_SHADOW, v);
      chk(v, 32'h0000_0042);
      rd(`FRS_IDX_DATA, v);
      chk(low_power, 1'b0);
      wr(`FRS_IDX_RATE, 32'h0000_0042);
      rd(`FRS_IDX_RATE, v);
      settle();
      chk(low_power, 1'b0);
      // code 11 differs from the bus reset code, so a lost rate would show
      wr(`FRS_IDX_RATE, 32'h0000_0043);
      fdc_soft_reset <= 1'b1;
      @(posedge hclk);
      fdc_soft_reset <= 1'b0;
      settle();
      chk(low_power, 1'b0);
      chk(data_rate_kbps, `FRS_KBPS_1M);
      rd(`FRS_IDX_SHADOW, v);
      chk(v, 32'h0000_0043);
      // self-clearing controller reset
      wr(`FRS_IDX_RATE, 32'h0000_0082);
      n = 0;
      repeat (10) begin
         @(posedge hclk);
         if (ctrl_reset === 1'b1) n++;
      end
      chk(n, 4);
      chk(ctrl_reset, 1'b0);
      conclude();
   end
endmodule

`default_nettype wire
